// File: src/arsp_pkg.sv
package arsp_pkg;
  // register byte offsets
  localparam logic [7:0] ARSP_CTRL_OFS = 8'h00;
  localparam logic [7:0] ARSP_CONV_OFS = 8'h04;
  localparam logic [7:0] ARSP_RESULT_OFS = 8'h08;
  localparam logic [7:0] ARSP_STATUS_OFS = 8'h0c;
  // control fields
  localparam int ARSP_CTRL_SERIAL_BIT = 0;
  localparam int ARSP_CTRL_CLKSRC_BIT = 1;
  localparam int ARSP_CTRL_MARKPOL_BIT = 2;
  localparam int ARSP_CTRL_EDGEINV_BIT = 3;
  localparam int ARSP_CTRL_RDC_BIT = 4;
  localparam int ARSP_CTRL_FORMAT_BIT = 5;
  localparam int ARSP_CTRL_WIDTH = 6;
  localparam logic [5:0] ARSP_CTRL_RESET = 6'h00;
  // status fields
  localparam int ARSP_STAT_CONV_BIT = 0;
  localparam int ARSP_STAT_MASTER_BIT = 1;
  localparam int ARSP_STAT_SLAVE_BIT = 2;
  localparam int ARSP_STAT_ERR_BIT = 3;
  localparam logic [15:0] ARSP_RESULT_RESET = 16'h0000;
  // frame geometry
  localparam int ARSP_FRAME_BITS = 16;
  localparam int ARSP_CHAIN_DELAY = 16;
  localparam int ARSP_PAR_LO = 5;
  localparam int ARSP_PAR_W = 6;
  // timing: master bit time is four equal phases
  localparam int ARSP_PCLK_NS = 50;
  localparam int ARSP_MASTER_BIT_NS = 200;
  localparam int ARSP_PHASE_CYC = (ARSP_MASTER_BIT_NS / 4) / ARSP_PCLK_NS < 1 ? 1 :
                                  (ARSP_MASTER_BIT_NS / 4) / ARSP_PCLK_NS;
  typedef enum logic {
    ARSP_M_IDLE = 1'b0,
    ARSP_M_RUN = 1'b1
  } arsp_mstate_t;
endpackage : arsp_pkg

// File: src/arsp_port.sv
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ns
// Function
// RQ1: parallel mode drives result bits five to ten
// RQ2: polarity select low gives active high marker
// RQ3: edge invert picks rising or falling clock
// RQ4: read-after-convert shifts current result when done
// RQ5: read-during-convert shifts previous result early
// RQ6: slave echoes chain input sixteen periods later
// RQ7: result shifted out most significant bit first
// RQ8: format select low inverts result MSB
// RQ9: master data valid on both clock edges
// RQ10: slave output changes on selected clock edge
// RQ11: clock pin direction follows clock source
// RQ12: source low is master, high follows host
// RQ13: master drives frame marker with its clock
// RQ14: marker active exactly while data bits valid
// RQ15: slave read cut by conversion flags error
// RQ16: every frame carries exactly sixteen data bits
module arsp_port import arsp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_result_clock_in,
  output logic serial_result_clock_out,
  output logic serial_result_clock_oe,
  input wire logic cs_n,
  input wire logic chain_input,
  output logic serial_result_out,
  output logic frame_marker,
  output logic read_error_flag,
  output logic [5:0] parallel_bits,
  output logic parallel_bits_oe
);
  ////////////////////////////////////////////////////////////////////////////
  logic [5:0] ctrl;
  logic [15:0] result_word;
  logic conv_busy;
  logic err_sticky;
  logic slave_busy;
  logic slave_out;
  logic link_clk;
  logic frame_rst;
  logic wr_en;
  logic setup;
  logic serial_mode;
  logic master_mode;
  logic mark_pol;
  logic edge_inv;
  logic read_during_convert_select;
  logic conv_write;
  logic result_write;
  logic slave_err;
  logic m_start;
  logic [15:0] m_load;
  arsp_mstate_t m_state;
  logic [1:0] m_phase;
  logic [4:0] m_bit;
  logic [2:0] m_div;
  logic m_tick;
  logic [15:0] m_sh;
  logic m_data;
  logic m_clk;
  logic m_mark;
  logic m_data_pin;
  logic slave_busy_link;
  logic [3:0] status;

  function automatic logic [15:0] fmt_result(input logic [15:0] raw, input logic straight);
    fmt_result = {raw[15] ^ ~straight, raw[14:0]}; // RQ8
  endfunction : fmt_result

  function automatic logic addr_is(input logic [31:0] a, input logic [7:0] ofs);
    addr_is = (a[31:8] == 24'h000000) && (a[7:0] == ofs);
  endfunction : addr_is

  assign serial_mode = ctrl[ARSP_CTRL_SERIAL_BIT];
  assign master_mode = serial_mode && !ctrl[ARSP_CTRL_CLKSRC_BIT]; // RQ12
  assign mark_pol = ctrl[ARSP_CTRL_MARKPOL_BIT];
  assign edge_inv = ctrl[ARSP_CTRL_EDGEINV_BIT];
  assign read_during_convert_select = ctrl[ARSP_CTRL_RDC_BIT];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign conv_write = wr_en && addr_is(paddr, ARSP_CONV_OFS) && pwdata[0];
  assign result_write = wr_en && addr_is(paddr, ARSP_RESULT_OFS);

  // status word built from the named bit positions
  always_comb begin
    status = 4'h0;
    status[ARSP_STAT_CONV_BIT] = conv_busy;
    status[ARSP_STAT_MASTER_BIT] = (m_state == ARSP_M_RUN);
    status[ARSP_STAT_SLAVE_BIT] = slave_busy;
    status[ARSP_STAT_ERR_BIT] = err_sticky;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access, read data captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      if (setup) begin
        prdata <= 32'h00000000;
        if (addr_is(paddr, ARSP_CTRL_OFS)) begin
          prdata <= {26'h0000000, ctrl};
        end else if (addr_is(paddr, ARSP_RESULT_OFS)) begin
          prdata <= {16'h0000, result_word};
        end else if (addr_is(paddr, ARSP_STATUS_OFS)) begin
          prdata <= {28'h0000000, status};
        end else if (!addr_is(paddr, ARSP_CONV_OFS)) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ARSP_CTRL_RESET;
    end else if (wr_en && addr_is(paddr, ARSP_CTRL_OFS)) begin
      ctrl <= pwdata[ARSP_CTRL_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion events stand in for the converter core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_busy <= 1'b0;
      result_word <= ARSP_RESULT_RESET;
    end else begin
      if (conv_write) begin
        conv_busy <= 1'b1;
      end
      if (result_write) begin
        conv_busy <= 1'b0;
        result_word <= fmt_result(pwdata[15:0], ctrl[ARSP_CTRL_FORMAT_BIT]); // RQ8
      end
    end
  end

  // the interrupted frame keeps old bits; host must discard it
  assign slave_err = result_write && serial_mode && !master_mode && slave_busy; // RQ15

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_error_flag <= 1'b0;
      err_sticky <= 1'b0;
    end else begin
      read_error_flag <= slave_err; // RQ15
      if (slave_err) begin
        err_sticky <= 1'b1;
      end else if (wr_en && addr_is(paddr, ARSP_STATUS_OFS) && pwdata[ARSP_STAT_ERR_BIT]) begin
        err_sticky <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master frame start
  always_comb begin
    m_start = 1'b0;
    m_load = result_word;
    if (master_mode && m_state == ARSP_M_IDLE) begin
      if (read_during_convert_select && conv_write) begin
        m_start = 1'b1; // RQ5
        m_load = result_word;
      end else if (!read_during_convert_select && result_write) begin
        m_start = 1'b1; // RQ4
        m_load = fmt_result(pwdata[15:0], ctrl[ARSP_CTRL_FORMAT_BIT]);
      end
    end
  end

  assign m_tick = (m_div == 3'(ARSP_PHASE_CYC - 1));

  // bit time: low, data change, high, high; data moves mid-low so
  // both edges see it settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_state <= ARSP_M_IDLE;
      m_phase <= 2'h0;
      m_bit <= 5'h00;
      m_div <= 3'h0;
      m_sh <= 16'h0000;
      m_data <= 1'b0;
      m_clk <= 1'b0;
      m_mark <= 1'b0;
    end else begin
      case (m_state)
        ARSP_M_IDLE: begin
          m_clk <= 1'b0;
          m_mark <= 1'b0;
          m_div <= 3'h0;
          m_phase <= 2'h0;
          m_bit <= 5'h00;
          if (m_start) begin
            m_sh <= m_load;
            m_state <= ARSP_M_RUN;
          end
        end
        ARSP_M_RUN: begin
          m_div <= m_tick ? 3'h0 : m_div + 3'h1;
          if (!master_mode) begin
            m_state <= ARSP_M_IDLE;
          end else if (m_tick) begin
            m_phase <= m_phase + 2'h1;
            case (m_phase)
              2'h0: begin
                if (m_bit < 5'(ARSP_FRAME_BITS)) begin
                  m_data <= m_sh[15]; // RQ9
                  m_sh <= {m_sh[14:0], 1'b0};
                  m_mark <= 1'b1; // RQ14
                end else begin
                  m_data <= 1'b0;
                  m_mark <= 1'b0; // RQ14
                  m_state <= ARSP_M_IDLE; // RQ16
                end
              end
              2'h1: begin
                m_clk <= 1'b1;
              end
              2'h2: begin
                m_clk <= 1'b1;
              end
              default: begin
                m_clk <= 1'b0;
                m_bit <= m_bit + 5'h01; // RQ16
              end
            endcase
          end
        end
        default: begin
          m_state <= ARSP_M_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin stage: serial clock pin and its enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_result_clock_out <= 1'b0;
      serial_result_clock_oe <= 1'b0;
    end else begin
      serial_result_clock_oe <= master_mode; // RQ11
      serial_result_clock_out <= master_mode ? (m_clk ^ edge_inv) : 1'b0; // RQ3
    end
  end

  // marker pin, same delay as the clock pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_marker <= 1'b0;
    end else begin
      frame_marker <= master_mode ? (m_mark ^ mark_pol) : 1'b0; // RQ2 RQ13
    end
  end

  // master data retimed with the clock pin; without it data would
  // move on the falling pin edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_data_pin <= 1'b0;
    end else begin
      m_data_pin <= m_data; // RQ9
    end
  end

  // parallel pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parallel_bits <= 6'h00;
      parallel_bits_oe <= 1'b0;
    end else begin
      parallel_bits_oe <= !serial_mode; // RQ1
      parallel_bits <= serial_mode ? 6'h00 : result_word[ARSP_PAR_LO +: ARSP_PAR_W]; // RQ1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave side on the host clock; edge invert must not change mid-frame
  assign link_clk = serial_result_clock_in ^ edge_inv; // RQ3 RQ10
  assign frame_rst = cs_n || !presetn || master_mode || !serial_mode; // RQ12

  arsp_slave_shift u_slave (
    .link_clk(link_clk),
    .frame_rst(frame_rst),
    .chain_input(chain_input),
    .word(result_word),
    .serial_out(slave_out),
    .frame_busy(slave_busy_link)
  );

  arsp_sync3 u_busy_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(slave_busy_link),
    .q(slave_busy)
  );

  // slave data must follow the host clock, so this pin is muxed, not re-timed
  assign serial_result_out = master_mode ? m_data_pin : (serial_mode ? slave_out : 1'b0); // RQ9
endmodule : arsp_port

// File: src/arsp_slave_shift.sv
`timescale 1ns/1ns
module arsp_slave_shift import arsp_pkg::*; (
  input wire logic link_clk,
  input wire logic frame_rst,
  input wire logic chain_input,
  input wire logic [15:0] word,
  output logic serial_out,
  output logic frame_busy
);
  logic [15:0] sh;
  logic [4:0] cnt;
  logic [4:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (cnt <= 5'(ARSP_CHAIN_DELAY)) begin
      next_cnt = cnt + 5'h01;
    end
  end

  // link clock stands still between frames; chip select ends each frame
  always_ff @(posedge link_clk or posedge frame_rst) begin
    if (frame_rst) begin
      cnt <= 5'h00;
      sh <= 16'h0000;
      serial_out <= 1'b0;
      frame_busy <= 1'b0;
    end else begin
      cnt <= next_cnt;
      frame_busy <= (next_cnt != 5'h00) && (next_cnt <= 5'(ARSP_FRAME_BITS));
      if (cnt == 5'h00) begin
        serial_out <= word[15]; // RQ7
        sh <= {word[14:0], chain_input}; // RQ6
      end else begin
        serial_out <= sh[15]; // RQ10
        sh <= {sh[14:0], chain_input}; // RQ6
      end
    end
  end
endmodule : arsp_slave_shift

// File: src/arsp_sync3.sv
`timescale 1ns/1ns
module arsp_sync3 import arsp_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic s1;
  logic s2;
  logic s3;

  // q moves only once the second and third stage agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule : arsp_sync3

// File: verification/arsp_host_model.sv
`timescale 1ns/1ns
module arsp_host_model (
  input wire logic sclk_out,
  input wire logic sdo,
  input wire logic marker,
  input wire logic mark_act,
  output logic lclk,
  output logic cs_n,
  output logic chain
);
  logic [31:0] got;
  logic [15:0] mgot;
  int mcnt;
  initial begin
    lclk = 1'b0;
    cs_n = 1'b1;
    chain = 1'b0;
    mcnt = 0;
  end
  // edges outside the marker never count as data
  always @(posedge sclk_out) begin
    if (marker === mark_act) begin
      mgot = {mgot[14:0], sdo};
      mcnt++;
    end
  end
  // clock stands at its idle level outside frames
  task automatic read(input int n, input logic inv, input logic [15:0] pat, input bit hold);
    lclk = inv;
    #20 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      chain = pat[15 - i % 16];
      #63 lclk = !inv;
      #62 lclk = inv;
      got = {got[30:0], sdo};
    end
    chain = !chain;
    if (!hold) cs_n = 1'b1;
  endtask : read
  task automatic clear_count();
    mcnt = 0;
  endtask : clear_count
  task automatic deselect();
    cs_n = 1'b1;
  endtask : deselect
endmodule : arsp_host_model

// File: verification/arsp_port_checker.sv
`timescale 1ns/1ns
module arsp_port_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_result_clock_out,
  input wire logic serial_result_clock_oe,
  input wire logic serial_result_out,
  input wire logic frame_marker,
  input wire logic read_error_flag,
  input wire logic [5:0] parallel_bits,
  input wire logic parallel_bits_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("stray slave error");
  a_error_one_pulse: assert property (read_error_flag |=> !read_error_flag)
    else $error("error flag not a pulse");
  a_error_slave_only: assert property (read_error_flag |-> !serial_result_clock_oe)
    else $error("error flag in master mode");
  a_par_bits_gated: assert property (!parallel_bits_oe |-> parallel_bits == 6'h00)
    else $error("parallel bits outside parallel mode");
  a_par_not_serial: assert property (parallel_bits_oe |-> !serial_result_clock_oe)
    else $error("serial clock in parallel mode");
  a_marker_master: assert property (frame_marker |->
    serial_result_clock_oe || $past(serial_result_clock_oe))
    else $error("marker outside master mode");
  a_data_mid_low: assert property (serial_result_clock_oe && $changed(serial_result_out)
    |-> $stable(serial_result_clock_out))
    else $error("data moved on a clock edge");
  a_clk_high_two: assert property (serial_result_clock_oe && $rose(serial_result_clock_out)
    |=> serial_result_clock_out)
    else $error("clock phase too short");
  c_frame: cover property ($rose(frame_marker));
  c_err: cover property (read_error_flag);
  c_slverr: cover property (pslverr);
endmodule : arsp_port_checker

bind arsp_port arsp_port_checker u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .serial_result_clock_out, .serial_result_clock_oe, .serial_result_out, .frame_marker,
  .read_error_flag, .parallel_bits, .parallel_bits_oe);

// File: verification/arsp_port_tb_top.sv
`timescale 1ns/1ns
module arsp_port_tb_top import arsp_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, mark_act, err_seen;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic serial_result_clock_in, serial_result_clock_out, serial_result_clock_oe, cs_n;
  logic chain_input, serial_result_out, frame_marker, read_error_flag, parallel_bits_oe;
  logic [5:0] parallel_bits;
  int miscompares = 0;
  int cmp_count = 0;
  arsp_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .serial_result_clock_in, .serial_result_clock_out, .serial_result_clock_oe,
    .cs_n, .chain_input, .serial_result_out, .frame_marker, .read_error_flag,
    .parallel_bits, .parallel_bits_oe);
  arsp_host_model host (.sclk_out(serial_result_clock_out), .sdo(serial_result_out),
    .marker(frame_marker), .mark_act, .lclk(serial_result_clock_in), .cs_n,
    .chain(chain_input));
  always #25 pclk = !pclk;
  always @(posedge pclk) if (read_error_flag === 1'b1) err_seen <= 1'b1;
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  ////////////////////////////////////////
  task automatic t_regs();
    apb(0, ARSP_CTRL_OFS, 0);
    check("ctrl reset", {26'h0, ARSP_CTRL_RESET}, rd);
    apb(0, 8'h10, 0);
    check("unmapped", 32'h1, {31'h0, perr});
    apb(1, ARSP_CTRL_OFS, 32'h20);
    apb(1, ARSP_RESULT_OFS, 32'ha5c3);
    repeat (2) @(posedge pclk);
    check("parallel", {25'h0, 7'h40 | 7'h2e}, {25'h0, parallel_bits_oe, parallel_bits});
    apb(1, ARSP_CTRL_OFS, 32'h00);
    apb(1, ARSP_RESULT_OFS, 32'ha5c3);
    apb(0, ARSP_RESULT_OFS, 0);
    check("twos result", 32'h25c3, rd);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_master(input logic p);
    int n;
    logic [15:0] r;
    n = 0;
    r = p ? 16'h3c5a : 16'hc35b;
    mark_act = !p;
    apb(1, ARSP_CTRL_OFS, {26'h0, 1'b1, p, 1'b0, p, 2'b01});
    repeat (2) @(posedge pclk);
    host.clear_count();
    check("marker idle", {31'h0, p}, {31'h0, frame_marker});
    check("clock oe", 32'h1, {31'h0, serial_result_clock_oe});
    apb(1, ARSP_RESULT_OFS, {16'h0, r});
    if (p) apb(1, ARSP_CONV_OFS, 32'h1);
    while (host.mcnt < 16 && n < 300) begin
      n++;
      @(posedge pclk);
    end
    repeat (12) @(posedge pclk);
    check("master bits", {16'h0, r}, {16'h0, host.mgot});
    check("master count", 32'd16, host.mcnt);
    $display("t_master done");
  endtask : t_master
  task automatic t_slave(input logic inv);
    apb(1, ARSP_CTRL_OFS, {26'h0, 2'b10, inv, 3'b011});
    apb(1, ARSP_RESULT_OFS, 32'h7e81);
    host.read(32, inv, 16'h9a6d, 0);
    check("slave bits", 32'h7e819a6d, host.got);
    check("clock oe", 32'h0, {31'h0, serial_result_clock_oe});
    $display("t_slave done");
  endtask : t_slave
  task automatic t_rderr();
    err_seen = 1'b0;
    host.read(8, 1'b1, 16'h0, 1);
    apb(1, ARSP_RESULT_OFS, 32'h1234);
    repeat (4) @(posedge pclk);
    check("read error", 32'h1, {31'h0, err_seen});
    apb(0, ARSP_STATUS_OFS, 0);
    check("status err", 32'h1, {31'h0, rd[ARSP_STAT_ERR_BIT]});
    host.deselect();
    apb(1, ARSP_STATUS_OFS, 32'h8);
    apb(0, ARSP_STATUS_OFS, 0);
    check("err cleared", 32'h0, {31'h0, rd[ARSP_STAT_ERR_BIT]});
    $display("t_rderr done");
  endtask : t_rderr
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #1000000;
    miscompares++;
    print_verdict();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    mark_act = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_master(1'b0);
    t_master(1'b1);
    t_slave(1'b0);
    t_slave(1'b1);
    t_rderr();
    print_verdict();
  end
endmodule : arsp_port_tb_top
